// File: hw/cms_core.sv
// contact monitor core: debounce, scan, wetting, alerts and serial register port
//
// Summary of operation
// - normal mode: change starts debounce; stable change updates status, alerts if enabled.
// - normal mode: input reverting before debounce end leaves status and alert alone.
// - scan mode: change wakes device into normal mode while input differs.
// - debounce done after wake: update status, alert, return to scan mode.
// - revert before debounce end after wake: back to scan, no alert, no update.
// - all wetting currents are off after power-up.
// - pulse select clear limits wetting to 20 ms; set keeps it on.
// - each debounced change starts wetting on closed, enabled switches after debounce.
// - in scan mode wetting is on only during the polling pulse.
// - pass outputs follow inputs 0,1 only in normal mode with pair bit clear.
// - pass inputs 0,1 never show in status and never raise alerts.
// - alert line pulled low when an unmasked input changes state.
// - alert line also pulled low on the first watchdog timeout.
// - chip select falling edge releases alert line and thermal alert.
// - warning temperature kills wetting only; critical level shuts regulator.
// - thermal flag bit is a live level, not cleared by chip select.
// - chip select fall loads the status word, shifted out MSB first.
// - serial output changes on rising clock, serial input sampled on falling.
// - chip select rise copies the whole shift register into the command word.
// - chip select high: serial output released, clock and data ignored.
// - status bits 15..8 report inputs 7..0, 1 = closed.
// - scan period halves per code from 64 ms to 2 ms; 110/111 continuous.
// - codes 110 and 111 select normal mode, other codes scan mode.
// - wetting on inputs 0,1 needs both global and pair enable bits.
// - a set mask bit blocks alerts from its input.
`timescale 1ns/10ps
`include "cms_params.svh"

module cms_core #(
  parameter int P_TICK_CYC = `CMS_CLK_HZ / 1000,
  parameter int P_POLL_CYC = `CMS_CLK_HZ / 1000000 * `CMS_POLL_US,
  parameter int P_DEB_MS   = `CMS_DEB_MS
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic             i_spi_clk,
  input  wire logic             i_cs_n,
  input  wire logic             i_sdi,
  output logic                  o_sdo,
  output logic                  o_sdo_oe_n,
  input  wire logic [7:0]       i_switch_closed,
  input  wire logic             i_temp_warn,
  input  wire logic             i_temp_crit,
  input  wire logic             i_first_dog_timeout,
  output logic                  o_alert_line_n,
  output logic                  o_alert_oe_n,
  output logic                  o_thermal_alert_n,
  output logic                  o_thermal_oe_n,
  output logic [1:0]            o_direct_pass_out,
  output logic [1:0]            o_direct_pass_oe_n,
  output logic [7:0]            o_wet_on,
  output logic                  o_sense_on,
  output logic [1:0]            o_upper_pair_polarity,
  output logic                  o_hyst_adj_off,
  output logic                  o_regulator_off,
  output cms_pkg::cms_word_t    o_configuration_word
);
  import cms_pkg::*;

  // scan period in ms for a periodic code; continuous codes never reach here
  function automatic logic [6:0] period_ms(input logic [2:0] sel);
    period_ms = 7'(`CMS_SCAN_MAX_MS >> sel);
  endfunction

  // ---------------- link side, clocked by the serial clock ----------------
  logic [4:0]  bit_cnt;
  cms_word_t   rx_sh;
  cms_word_t   stat_hold;
  logic        sdo_q;

  // falling edges count bits; chip select high holds the count at zero
  always_ff @(negedge i_spi_clk or posedge i_rst or posedge i_cs_n) begin
    if (i_rst || i_cs_n) begin
      bit_cnt <= 5'h00;
    end else if (bit_cnt != 5'h10) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // input sampled on the falling edge, only inside a frame
  always_ff @(negedge i_spi_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_sh <= `CMS_CFG_RESET;
    end else if (!i_cs_n) begin
      rx_sh <= {rx_sh[14:0], i_sdi};
    end
  end

  // output bit changes on the rising edge, msb first from the frozen snapshot
  always_ff @(posedge i_spi_clk or posedge i_rst or posedge i_cs_n) begin
    if (i_rst || i_cs_n) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= stat_hold[~bit_cnt[3:0]];
    end
  end
  assign o_sdo = sdo_q;

  // ---------------- core side, clocked by i_clock ----------------
  logic       cs_m1, cs_s, cs_d;
  logic [7:0] sw_m1, sw_in;
  logic [2:0] ta_m1, ta_s;
  logic       dog_d;
  cms_word_t  cfg;
  cms_state_t state;
  logic [7:0] sw_state, target, samp;
  logic       awake;
  logic [14:0] tick_cnt;
  logic [6:0] deb_ms, scan_ms;
  logic [4:0] wet_ms;
  logic       wet_run;
  logic [12:0] poll_cnt;
  logic       poll_on;
  logic       alert_pend, therm_pend, hot_d;

  // two-stage synchronisers for the switch, thermal and watchdog pins and for chip select
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cs_m1 <= 1'b1;
      cs_s  <= 1'b1;
      cs_d  <= 1'b1;
      sw_m1 <= 8'h00;
      sw_in <= 8'h00;
      ta_m1 <= 3'h0;
      ta_s  <= 3'h0;
    end else begin
      cs_m1 <= i_cs_n;
      cs_s  <= cs_m1;
      cs_d  <= cs_s;
      sw_m1 <= i_switch_closed;
      sw_in <= sw_m1;
      ta_m1 <= {i_first_dog_timeout, i_temp_crit, i_temp_warn};
      ta_s  <= ta_m1;
    end
  end

  // decoded modes and enables
  wire       cs_fall   = cs_d & ~cs_s;
  wire       cs_rise   = ~cs_d & cs_s;
  wire       hot       = ta_s[0];
  wire       dog_rise  = ta_s[2] & ~dog_d;
  wire [2:0] sc_sel    = cfg[`CMS_SCAN_HI:`CMS_SCAN_LO];
  wire       normal    = (sc_sel[2:1] == `CMS_SCAN_CONT);
  wire       pair_on   = cfg[`CMS_PAIR_BIT];
  wire       pass_mode = normal & ~pair_on;
  wire [7:0] elig      = {6'h3f, {2{~pass_mode}}};
  wire [7:0] irq_mask  = cfg[`CMS_MASK_HI:0];
  wire       live      = normal | awake;
  wire [7:0] seen      = live ? sw_in : samp;
  wire [7:0] diff      = (seen ^ sw_state) & elig;
  wire       tick      = (tick_cnt == 15'(P_TICK_CYC - 1));
  // the first tick may land at once, so one more tick guarantees the full time
  wire       deb_done  = (state == ST_DEB) & tick & (deb_ms == 7'(P_DEB_MS));
  wire [7:0] alert_chg = (target ^ sw_state) & elig & ~irq_mask;
  wire       alert_set = (deb_done & (|alert_chg)) | dog_rise;
  wire       therm_set = hot & ~hot_d;
  wire [7:0] wet_en    = {{6{cfg[`CMS_WEN_BIT]}}, {2{cfg[`CMS_WEN_BIT] & pair_on}}};
  wire       wet_gate  = cfg[`CMS_WPS_BIT] | wet_run;
  wire       wet_time  = live ? wet_gate : (poll_on & wet_gate);
  wire [7:0] next_wet  = hot ? 8'h00 : (sw_state & elig & wet_en & {8{wet_time}});
  wire [15:0] stat_word = {sw_state & elig, hot, 7'h00};

  // free-running millisecond timebase shared by the scan, debounce and wetting timers
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt <= 15'h0000;
    end else begin
      tick_cnt <= tick ? 15'h0000 : tick_cnt + 15'h0001;
    end
  end

  // command word: whole shift register taken at chip select rise
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cfg <= `CMS_CFG_RESET;
    end else if (cs_rise) begin
      cfg <= rx_sh;
    end
  end

  // snapshot follows the status word until the frame starts, then freezes
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      stat_hold <= `CMS_CFG_RESET;
    end else if (cs_s) begin
      stat_hold <= stat_word;
    end
  end

  // scan polling: one pulse of P_POLL_CYC cycles per period, sampled at its end
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      scan_ms  <= 7'h00;
      poll_cnt <= 13'h0000;
      poll_on  <= 1'b0;
      samp     <= 8'h00;
    end else if (live) begin
      scan_ms  <= 7'h00;
      poll_on  <= 1'b0;
      poll_cnt <= 13'h0000;
      samp     <= sw_in;
    end else if (poll_on) begin
      poll_cnt <= poll_cnt + 13'h0001;
      if (poll_cnt == 13'(P_POLL_CYC - 1)) begin
        poll_on <= 1'b0;
        samp    <= sw_in;
      end
    end else if (tick) begin
      if (scan_ms >= period_ms(sc_sel) - 7'h01) begin
        scan_ms  <= 7'h00;
        poll_on  <= 1'b1;
        poll_cnt <= 13'h0000;
      end else begin
        scan_ms <= scan_ms + 7'h01;
      end
    end
  end

  // debounce: one shared timer, restarted whenever the pending level moves
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state    <= ST_IDLE;
      target   <= 8'h00;
      sw_state <= 8'h00;
      deb_ms   <= 7'h00;
      awake    <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (|diff) begin
            state  <= ST_DEB;
            target <= seen;
            deb_ms <= 7'h00;
            awake  <= ~normal;
          end
        end
        ST_DEB: begin
          if (~|diff) begin
            state <= ST_IDLE;
            awake <= 1'b0;
          end else if ((seen & elig) != (target & elig)) begin
            target <= seen;
            deb_ms <= 7'h00;
          end else if (deb_done) begin
            state    <= ST_IDLE;
            sw_state <= target;
            awake    <= 1'b0;
          end else if (tick) begin
            deb_ms <= deb_ms + 7'h01;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // single wetting timer; a new debounced change retriggers it
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wet_run <= 1'b0;
      wet_ms  <= 5'h00;
    end else if (deb_done) begin
      wet_run <= 1'b1;
      wet_ms  <= 5'h00;
    end else if (wet_run && tick) begin
      if (wet_ms == 5'(`CMS_WET_MS - 1)) begin
        wet_run <= 1'b0;
      end
      wet_ms <= wet_ms + 5'h01;
    end
  end

  // sticky alerts: a new event in the clearing cycle wins over the clear
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      alert_pend <= 1'b0;
      therm_pend <= 1'b0;
      hot_d      <= 1'b0;
      dog_d      <= 1'b0;
    end else begin
      hot_d      <= hot;
      dog_d      <= ta_s[2];
      alert_pend <= alert_set | (alert_pend & ~cs_fall);
      therm_pend <= therm_set | (therm_pend & ~cs_fall);
    end
  end

  // registered pin drivers; open-drain lines only ever drive low
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_sdo_oe_n            <= 1'b1;
      o_alert_line_n        <= 1'b0;
      o_alert_oe_n          <= 1'b1;
      o_thermal_alert_n     <= 1'b0;
      o_thermal_oe_n        <= 1'b1;
      o_direct_pass_out     <= 2'h0;
      o_direct_pass_oe_n    <= 2'h3;
      o_wet_on              <= 8'h00;
      o_sense_on            <= 1'b0;
      o_upper_pair_polarity <= 2'h0;
      o_hyst_adj_off        <= 1'b0;
      o_regulator_off       <= 1'b0;
      o_configuration_word  <= `CMS_CFG_RESET;
    end else begin
      o_sdo_oe_n            <= cs_s;
      o_alert_line_n        <= 1'b0;
      o_alert_oe_n          <= ~alert_pend;
      o_thermal_alert_n     <= 1'b0;
      o_thermal_oe_n        <= ~therm_pend;
      o_direct_pass_out     <= sw_in[1:0];
      o_direct_pass_oe_n    <= {2{~pass_mode}};
      o_wet_on              <= next_wet;
      o_sense_on            <= live | poll_on;
      o_upper_pair_polarity <= cfg[`CMS_POL_HI:`CMS_POL_LO];
      o_hyst_adj_off        <= (sc_sel == 3'h6);
      o_regulator_off       <= ta_s[1];
      o_configuration_word  <= cfg;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  chk_alert_cs_clear: assert property (
    cs_fall && !alert_set |=> ##1 o_alert_oe_n)
    else $error("alert not released after chip select fall");
  chk_therm_cs_clear: assert property (
    cs_fall && !therm_set |=> ##1 o_thermal_oe_n)
    else $error("thermal alert not released after chip select fall");
  chk_status_only_done: assert property (
    $changed(sw_state) |-> $past(deb_done))
    else $error("status changed without finished debounce");
  chk_revert_no_update: assert property (
    state == ST_DEB && !(|diff) |=> state == ST_IDLE && $stable(sw_state))
    else $error("reverted input still updated status");
  chk_wake_normal: assert property (
    state == ST_IDLE && (|diff) && !normal |=> awake && state == ST_DEB)
    else $error("scan change did not wake device");
  chk_back_to_scan: assert property (
    state == ST_DEB ##1 state == ST_IDLE |-> !awake)
    else $error("device stayed awake after debounce end");
  chk_hot_wet_off: assert property (
    hot |=> o_wet_on == 8'h00)
    else $error("wetting on while over temperature");
  chk_pass_hiz: assert property (
    !pass_mode |=> o_direct_pass_oe_n == 2'h3)
    else $error("pass outputs driven outside pass mode");
  chk_pass_status: assert property (
    pass_mode |-> stat_word[9:8] == 2'h0 && !alert_chg[0] && !alert_chg[1])
    else $error("pass inputs visible in status or alerts");
  chk_dog_alert: assert property (
    dog_rise |=> ##1 !o_alert_oe_n)
    else $error("watchdog timeout did not pull alert");
  chk_mask_block: assert property (
    deb_done && alert_chg == 8'h00 && !dog_rise && !alert_pend |=> !alert_pend)
    else $error("masked change raised alert");
  chk_cfg_load: assert property (
    cs_rise |=> cfg == $past(rx_sh))
    else $error("command word not loaded at chip select rise");
  chk_scan_wet_poll: assert property (
    !live && !poll_on |=> o_wet_on == 8'h00)
    else $error("wetting on in scan mode outside a poll pulse");

endmodule // cms_core

// File: hw/cms_params.svh
// constants for the contact monitor core: field positions, reset values, timing
`ifndef CMS_PARAMS_SVH
`define CMS_PARAMS_SVH
`define CMS_WORD_BITS   16
`define CMS_CFG_RESET   16'h0000
`define CMS_WPS_BIT     15
`define CMS_SCAN_HI     14
`define CMS_SCAN_LO     12
`define CMS_WEN_BIT     11
`define CMS_PAIR_BIT    10
`define CMS_POL_HI      9
`define CMS_POL_LO      8
`define CMS_MASK_HI     7
`define CMS_SW_HI       15
`define CMS_SW_LO       8
`define CMS_THERM_BIT   7
`define CMS_SCAN_CONT   2'h3
`define CMS_SCAN_MAX_MS 64
`define CMS_CLK_HZ      25000000
`define CMS_WET_MS      20
`define CMS_POLL_US     250
`define CMS_DEB_MS      5
`endif

// File: hw/cms_pkg.sv
// types shared by the contact monitor core
`include "cms_params.svh"
package cms_pkg;
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_DEB
  } cms_state_t;
  typedef logic [`CMS_WORD_BITS-1:0] cms_word_t;
endpackage

// File: test/cms_spi_host.sv
// host side model: spi master clocking one 16-bit frame per call
`timescale 1ns/10ps
module cms_spi_host (
  output logic        o_sck,
  output logic        o_cs_n,
  output logic        o_sdi,
  input  wire logic   i_sdo,
  input  wire logic   i_sdo_oe_n,
  output logic [15:0] o_rx,
  output logic        o_rx_vld
);
  initial begin
    o_sck    = 1'b0;
    o_cs_n   = 1'b1;
    o_sdi    = 1'b0;
    o_rx     = 16'h0000;
    o_rx_vld = 1'b0;
  end

  // data line is junk between frames, so a slave that listens then is caught
  always #7 if (o_cs_n) o_sdi = ~o_sdi;

  // link clock runs only inside the frame, 6 ns period, exactly 16 bits
  task automatic frame(input logic [15:0] tx);
    logic [15:0] rx;
    o_cs_n = 1'b0;
    #240;
    for (int i = 15; i >= 0; i--) begin
      // data moves 1 ns after the falling edge so the slave never races it
      #1 o_sdi = tx[i];
      #2 o_sck = 1'b1;
      #3 rx[i] = i_sdo_oe_n ? ~i_sdo : i_sdo; // released line reads garbage
      o_sck = 1'b0;
    end
    #3 o_cs_n = 1'b1;
    o_rx = rx;
    o_rx_vld = 1'b1;
    #40 o_rx_vld = 1'b0;
    #360;
  endtask
endmodule // cms_spi_host

// File: test/contact_monitor_spi_core_tb.sv
// self-checking bench for the contact monitor core
`timescale 1ns/10ps
module contact_monitor_spi_core_tb;
  import cms_pkg::*;
  logic        i_clock = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_spi_clk, i_cs_n, i_sdi, o_sdo, o_sdo_oe_n;
  logic [7:0]  i_switch_closed = 8'h00;
  logic        i_temp_warn = 1'b0;
  logic        i_temp_crit = 1'b0;
  logic        i_first_dog_timeout = 1'b0;
  logic        o_alert_line_n, o_alert_oe_n, o_thermal_alert_n, o_thermal_oe_n;
  logic [1:0]  o_direct_pass_out, o_direct_pass_oe_n, o_upper_pair_polarity;
  logic [7:0]  o_wet_on, sw;
  logic        o_sense_on, o_hyst_adj_off, o_regulator_off, rx_vld;
  cms_word_t   o_configuration_word, rx_word, cfg;
  logic [15:0] q[$];
  int          n_errors = 0;
  int          n_checks = 0;
  int          seed = 39;

  always #20 i_clock = ~i_clock;

  // short counts keep the run small: 1 ms tick is 10 cycles
  cms_core #(.P_TICK_CYC(10), .P_POLL_CYC(4), .P_DEB_MS(2)) dut (
    .i_clock, .i_rst, .i_spi_clk, .i_cs_n, .i_sdi, .o_sdo, .o_sdo_oe_n,
    .i_switch_closed, .i_temp_warn, .i_temp_crit, .i_first_dog_timeout,
    .o_alert_line_n, .o_alert_oe_n, .o_thermal_alert_n, .o_thermal_oe_n,
    .o_direct_pass_out, .o_direct_pass_oe_n, .o_wet_on, .o_sense_on,
    .o_upper_pair_polarity, .o_hyst_adj_off, .o_regulator_off, .o_configuration_word);

  cms_spi_host host (.o_sck(i_spi_clk), .o_cs_n(i_cs_n), .o_sdi(i_sdi), .i_sdo(o_sdo),
    .i_sdo_oe_n(o_sdo_oe_n), .o_rx(rx_word), .o_rx_vld(rx_vld));

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] s, input logic [15:0] e, input string nm);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_clock);
    #2;
  endtask

  // every frame reads status and rewrites the whole command word
  task automatic xfer(input logic [15:0] e);
    q.push_back(e);
    host.frame(cfg);
    step(10);
    chk(o_configuration_word, cfg, "cfg");
  endtask

  // watcher: oldest expected status against each word read back
  always @(posedge rx_vld) chk(rx_word, q.pop_front(), "status");

  initial begin
    #1000000;
    n_errors++;
    final_report();
  end

  initial begin
    repeat (16) @(posedge i_clock);
    #2 i_rst = 1'b0;
    step(4);
    chk(o_configuration_word, 16'h0000, "cfg_reset");
    chk(o_wet_on, 8'h00, "wet_reset");
    chk(o_direct_pass_oe_n, 2'b11, "pass_scan");
    cfg = 16'h0000;
    xfer(16'h0000);
    // normal mode, global and pair wetting, timed pulse
    cfg = 16'h7c00 | (16'($random(seed)) & 16'h0300);
    xfer(16'h0000);
    chk(o_upper_pair_polarity, cfg[9:8], "polarity");
    chk(o_sense_on, 1'b1, "sense_norm");
    chk(o_hyst_adj_off, 1'b0, "hyst_on");
    sw = 8'($random(seed)) | 8'h01;
    i_switch_closed = sw;
    step(50);
    chk(o_alert_oe_n, 1'b0, "alert");
    chk(o_alert_line_n, 1'b0, "alert_lvl");
    chk(o_wet_on, sw, "wet");
    xfer({sw, 8'h00});
    chk(o_alert_oe_n, 1'b1, "alert_clr");
    step(250);
    chk(o_wet_on, 8'h00, "wet_end");
    // short glitch is shorter than the debounce floor
    i_switch_closed = sw ^ 8'h80;
    step(4);
    i_switch_closed = sw;
    step(50);
    chk(o_alert_oe_n, 1'b1, "glitch");
    xfer({sw, 8'h00});
    // masked input updates status without an alert
    cfg = cfg | 16'h0080;
    xfer({sw, 8'h00});
    sw = sw ^ 8'h80;
    i_switch_closed = sw;
    step(50);
    chk(o_alert_oe_n, 1'b1, "masked");
    xfer({sw, 8'h00});
    // pass mode for inputs 0 and 1, continuous wetting
    cfg = (cfg & 16'hfbff) | 16'h8000;
    xfer({sw, 8'h00});
    chk(o_direct_pass_oe_n, 2'b00, "pass_oe");
    sw = sw ^ 8'h01;
    i_switch_closed = sw;
    step(50);
    chk(o_direct_pass_out, sw[1:0], "pass_out");
    chk(o_alert_oe_n, 1'b1, "pass_alert");
    step(250);
    chk(o_wet_on, sw & 8'hfc, "wet_cont");
    xfer({sw & 8'hfc, 8'h00});
    // put input 0 back so leaving pass mode later shows no stale change
    sw = sw ^ 8'h01;
    i_switch_closed = sw;
    // thermal warning and critical level
    i_temp_warn = 1'b1;
    i_temp_crit = 1'b1;
    step(6);
    chk(o_thermal_oe_n, 1'b0, "therm");
    chk(o_thermal_alert_n, 1'b0, "therm_lvl");
    chk(o_regulator_off, 1'b1, "reg_off");
    chk(o_wet_on, 8'h00, "wet_hot");
    xfer({sw & 8'hfc, 8'h80});
    chk(o_thermal_oe_n, 1'b1, "therm_clr");
    xfer({sw & 8'hfc, 8'h80});
    i_temp_warn = 1'b0;
    i_temp_crit = 1'b0;
    step(6);
    chk(o_wet_on, sw & 8'hfc, "wet_back");
    xfer({sw & 8'hfc, 8'h00});
    // first watchdog timeout pulls the alert line
    i_first_dog_timeout = 1'b1;
    step(6);
    chk(o_alert_oe_n, 1'b0, "dog");
    // scan mode at the 2 ms period, wake on a change
    cfg = (cfg & 16'h8f00) | 16'h5400;
    xfer({sw & 8'hfc, 8'h00});
    chk(o_direct_pass_oe_n, 2'b11, "pass_scan2");
    chk(o_alert_oe_n, 1'b1, "dog_clr");
    sw = sw ^ 8'h40;
    i_switch_closed = sw;
    step(80);
    chk(o_alert_oe_n, 1'b0, "scan_alert");
    xfer({sw, 8'h00});
    // code 110: continuous monitoring with adjustable hysteresis off
    cfg = (cfg & 16'h8fff) | 16'h6000;
    xfer({sw, 8'h00});
    chk(o_hyst_adj_off, 1'b1, "hyst_off");
    chk(o_sense_on, 1'b1, "sense_cont");
    step(5);
    final_report();
  end
endmodule // contact_monitor_spi_core_tb
